// ### rtl/cbtf_pkg.sv
// package: register map, field layout and timing constants for the can config block
package cbtf_pkg;
   // ********************************************
   // register map
   // ********************************************
   localparam logic [3:0] CBTF_OFS_TIMING = 4'h0;
   localparam logic [3:0] CBTF_OFS_FILTER = 4'h4;
   localparam logic [3:0] CBTF_OFS_MODE = 4'h8;
   localparam logic [3:0] CBTF_OFS_STATUS = 4'hC;
   localparam logic [31:0] CBTF_TIMING_RST = 32'h0000_0000;
   localparam logic [31:0] CBTF_FILTER_RST = 32'h0000_0000;
   localparam logic [2:0] CBTF_MODE_RST = 3'h4;
   // ********************************************
   // timing register fields
   // ********************************************
   localparam int CBTF_WAKE_BIT = 22;
   localparam int CBTF_PH2_LSB = 16;
   localparam int CBTF_FREE_BIT = 15;
   localparam int CBTF_TRIPLE_BIT = 14;
   localparam int CBTF_PH1_LSB = 11;
   localparam int CBTF_PROP_LSB = 8;
   localparam int CBTF_SJW_LSB = 6;
   localparam int CBTF_BRP_LSB = 0;
   localparam logic [31:0] CBTF_TIMING_MASK = 32'h0047_FFFF;
   // ********************************************
   // filter control fields
   // ********************************************
   localparam int CBTF_FLT_STRIDE = 8;
   localparam int CBTF_FLT_EN_BIT = 7;
   localparam int CBTF_FLT_MASK_LSB = 5;
   localparam int CBTF_FLT_FIFO_LSB = 0;
   localparam logic [7:0] CBTF_FLT_CFG_MASK = 8'h7F;
   // ********************************************
   // mode and timing figures
   // ********************************************
   localparam logic [2:0] CBTF_MODE_CONFIG = 3'h4;
   localparam logic [3:0] CBTF_IPT_TQ = 4'h2;
   localparam logic [4:0] CBTF_MIN_TQ_BIT = 5'h08;
endpackage

// ### rtl/cbtf_filter_slot.sv
// one acceptance filter slot: enable, mask choice and fifo target
`timescale 1ns/100ps
module cbtf_filter_slot
   import cbtf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic [28:0] msg_id,
   input wire logic msg_valid,
   input wire logic [28:0] mask0,
   input wire logic [28:0] mask1,
   input wire logic [28:0] mask2,
   input wire logic [28:0] mask3,
   input wire logic [28:0] filt_id,
   output logic [7:0] cfg,
   output logic hit
);
   typedef struct packed {
      logic en;
      logic [1:0] msel;
      logic [4:0] fifo;
   } cbtf_slot_t;
   cbtf_slot_t st_q;
   cbtf_slot_t st_d;
   logic [28:0] msk;

   always_comb begin
      st_d = st_q;
      if (wr) begin
         st_d.en = wdata[CBTF_FLT_EN_BIT];
         // routing fields locked while the filter is live
         if (!st_q.en) begin
            st_d.msel = wdata[CBTF_FLT_MASK_LSB +: 2];
            st_d.fifo = wdata[CBTF_FLT_FIFO_LSB +: 5];
         end
      end
   end

   always_comb begin
      case (st_q.msel)
         2'h0: msk = mask0;
         2'h1: msk = mask1;
         2'h2: msk = mask2;
         2'h3: msk = mask3;
         default: msk = mask0;
      endcase
   end

   assign hit = st_q.en && msg_valid && (((msg_id ^ filt_id) & msk) == '0);
   assign cfg = {st_q.en, st_q.msel, st_q.fifo};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// ### rtl/cbtf_top.sv
// can bit-timing configuration and acceptance filter control
//
// Overview of operation
// - wake filter bit enables bus line filter
// - phase2 length is field plus one
// - free select off: phase2 is max(ph1,ipt) capped at ph1, so it equals ph1
// - triple read bit samples bus three times
// - phase1 length is field plus one
// - phase2 never above phase1, auto loaded
// - timing writes only in config mode
// - filter matches only while enabled
// - mask choice selects acceptance mask 0-3
// - fifo target names fifo 0 to 31
// - routing fields locked while filter enabled
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module cbtf_top
   import cbtf_pkg::*;
#(
   parameter int NFILT = 2
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   input wire logic can_rx_pin,
   input wire logic [28:0] msg_id,
   input wire logic msg_valid,
   input wire logic [28:0] mask0,
   input wire logic [28:0] mask1,
   input wire logic [28:0] mask2,
   input wire logic [28:0] mask3,
   input wire logic [28:0] filt_id0,
   input wire logic [28:0] filt_id1,
   output logic tq_tick,
   output logic sample_bit,
   output logic sample_strobe,
   output logic wake_detect,
   output logic [3:0] phase1_tq,
   output logic [3:0] phase2_tq,
   output logic [2:0] sjw_tq,
   output logic match_valid,
   output logic [4:0] match_fifo
);
   // ********************************************
   // state
   // ********************************************
   typedef enum logic [1:0] {
      CBTF_SYNC = 2'b00,
      CBTF_PROP = 2'b01,
      CBTF_PH1 = 2'b10,
      CBTF_PH2 = 2'b11
   } cbtf_seg_t;

   typedef struct packed {
      logic [31:0] timing;
      logic [2:0] mode;
      logic [31:0] rdata;
      logic [1:0] rx_sync;
      logic [2:0] wake_sh;
      logic wake;
      logic [6:0] pre_cnt;
      logic tick;
      cbtf_seg_t seg;
      logic [3:0] seg_cnt;
      logic [2:0] samp;
      logic sbit;
      logic sstb;
      logic [3:0] ph1;
      logic [3:0] ph2;
      logic [2:0] resync_jump_width;
      logic mval;
      logic [4:0] mfifo;
   } cbtf_state_t;

   cbtf_state_t s_q;
   cbtf_state_t s_d;

   logic [NFILT*8-1:0] flt_cfg;
   logic [NFILT-1:0] flt_hit;
   logic [28:0] fid [NFILT];
   logic flt_wr;

   assign fid[0] = filt_id0;
   assign fid[1] = filt_id1;
   assign flt_wr = wr_stb && (addr == CBTF_OFS_FILTER);

   // ********************************************
   // filter slots
   // ********************************************
   genvar gi;
   generate
      for (gi = 0; gi < NFILT; gi++) begin : g_flt
         cbtf_filter_slot u_slot (
            .clk(clk),
            .rst_b(rst_b),
            .wr(flt_wr),
            .wdata(wdata[gi*CBTF_FLT_STRIDE +: 8]),
            .msg_id(msg_id),
            .msg_valid(msg_valid),
            .mask0(mask0),
            .mask1(mask1),
            .mask2(mask2),
            .mask3(mask3),
            .filt_id(fid[gi]),
            .cfg(flt_cfg[gi*8 +: 8]),
            .hit(flt_hit[gi])
         );
      end
   endgenerate

   // ********************************************
   // next state
   // ********************************************
   logic [3:0] f_ph1;
   logic [3:0] f_ph2;
   logic [3:0] ph2_eff;
   logic [3:0] prop_tq;
   logic [4:0] tq_bit;
   logic [6:0] pre_max;
   logic [3:0] seg_len;
   logic rx_now;
   logic maj;

   always_comb begin
      s_d = s_q;
      // field decode: field value plus one quantum
      f_ph1 = {1'b0, s_q.timing[CBTF_PH1_LSB +: 3]} + 4'h1;
      f_ph2 = {1'b0, s_q.timing[CBTF_PH2_LSB +: 3]} + 4'h1;
      prop_tq = {1'b0, s_q.timing[CBTF_PROP_LSB +: 3]} + 4'h1;
      if (s_q.timing[CBTF_FREE_BIT]) begin
         ph2_eff = f_ph2;
      end else begin
         ph2_eff = (f_ph1 > CBTF_IPT_TQ) ? f_ph1 : CBTF_IPT_TQ;
      end
      // clamp keeps phase2 from exceeding phase1
      if (ph2_eff > f_ph1) begin
         ph2_eff = f_ph1;
      end
      tq_bit = 5'h01 + {1'b0, prop_tq} + {1'b0, f_ph1} + {1'b0, ph2_eff};
      pre_max = {s_q.timing[CBTF_BRP_LSB +: 6], 1'b1};
      s_d.ph1 = f_ph1;
      s_d.ph2 = ph2_eff;
      s_d.resync_jump_width = {1'b0, s_q.timing[CBTF_SJW_LSB +: 2]} + 3'h1;

      // register bus
      if (wr_stb) begin
         case (addr)
            CBTF_OFS_TIMING: begin
               if (s_q.mode == CBTF_MODE_CONFIG) begin
                  s_d.timing = wdata & CBTF_TIMING_MASK;
               end
            end
            CBTF_OFS_MODE: s_d.mode = wdata[2:0];
            default: ;
         endcase
      end
      s_d.rdata = '0;
      if (rd_stb) begin
         case (addr)
            CBTF_OFS_TIMING: s_d.rdata = s_q.timing;
            CBTF_OFS_FILTER: s_d.rdata = {16'h0000, flt_cfg};
            CBTF_OFS_MODE: s_d.rdata = {29'h0, s_q.mode};
            CBTF_OFS_STATUS: s_d.rdata = {19'h0, tq_bit, s_q.ph2, s_q.ph1};
            default: s_d.rdata = '0;
         endcase
      end

      // quantum divider: period of 2*(prescaler+1) clocks
      s_d.tick = 1'b0;
      if (s_q.pre_cnt >= pre_max) begin
         s_d.pre_cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.pre_cnt = s_q.pre_cnt + 7'h01;
      end

      // bus input, optionally filtered for wake-up
      s_d.rx_sync = {s_q.rx_sync[0], can_rx_pin};
      s_d.wake_sh = {s_q.wake_sh[1:0], s_q.rx_sync[1]};
      if (s_q.timing[CBTF_WAKE_BIT]) begin
         // glitch filter: three equal dominant samples needed
         s_d.wake = (s_q.wake_sh == 3'b000);
      end else begin
         s_d.wake = !s_q.rx_sync[1];
      end
      rx_now = s_q.rx_sync[1];

      // segment sequencer, one step per quantum
      case (s_q.seg)
         CBTF_SYNC: seg_len = 4'h1;
         CBTF_PROP: seg_len = prop_tq;
         CBTF_PH1: seg_len = s_q.ph1;
         CBTF_PH2: seg_len = s_q.ph2;
         default: seg_len = 4'h1;
      endcase
      maj = (s_q.samp[0] & s_q.samp[1]) | (s_q.samp[0] & s_q.samp[2]) |
         (s_q.samp[1] & s_q.samp[2]);
      s_d.sstb = 1'b0;
      if (s_q.tick) begin
         s_d.samp = {s_q.samp[1:0], rx_now};
         if (s_q.seg_cnt + 4'h1 >= seg_len) begin
            s_d.seg_cnt = '0;
            case (s_q.seg)
               CBTF_SYNC: s_d.seg = CBTF_PROP;
               CBTF_PROP: s_d.seg = CBTF_PH1;
               CBTF_PH1: begin
                  s_d.seg = CBTF_PH2;
                  s_d.sstb = 1'b1;
                  // majority of last three quanta versus single read
                  if (s_q.timing[CBTF_TRIPLE_BIT]) begin
                     s_d.sbit = maj;
                  end else begin
                     s_d.sbit = rx_now;
                  end
               end
               CBTF_PH2: s_d.seg = CBTF_SYNC;
               default: s_d.seg = CBTF_SYNC;
            endcase
         end else begin
            s_d.seg_cnt = s_q.seg_cnt + 4'h1;
         end
      end

      // filter result, lowest filter wins
      s_d.mval = |flt_hit;
      s_d.mfifo = s_q.mfifo;
      for (int i = NFILT - 1; i >= 0; i--) begin
         if (flt_hit[i]) begin
            s_d.mfifo = flt_cfg[i*8 +: 5];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.timing <= CBTF_TIMING_RST;
         s_q.mode <= CBTF_MODE_RST;
         s_q.rx_sync <= 2'b11;
         s_q.wake_sh <= 3'b111;
         s_q.samp <= 3'b111;
         s_q.sbit <= 1'b1;
         s_q.ph1 <= 4'h1;
         s_q.ph2 <= 4'h1;
         s_q.resync_jump_width <= 3'h1;
      end else begin
         s_q <= s_d;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   assign rdata = s_q.rdata;
   assign tq_tick = s_q.tick;
   assign sample_bit = s_q.sbit;
   assign sample_strobe = s_q.sstb;
   assign wake_detect = s_q.wake;
   assign phase1_tq = s_q.ph1;
   assign phase2_tq = s_q.ph2;
   assign sjw_tq = s_q.resync_jump_width;
   assign match_valid = s_q.mval;
   assign match_fifo = s_q.mfifo;
endmodule

// ### tb/cbtf_sva.sv
// checker: port-level assertions for the can config block
`timescale 1ns/100ps
module cbtf_sva
   import cbtf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [31:0] rdata,
   input wire logic msg_valid,
   input wire logic tq_tick,
   input wire logic [3:0] phase1_tq,
   input wire logic [3:0] phase2_tq,
   input wire logic [2:0] sjw_tq,
   input wire logic match_valid
);
   // ****************************************
   // mode shadow and properties
   // ****************************************
   // the mode register is not a port, so it is shadowed from bus writes
   logic [2:0] mode_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= CBTF_MODE_RST;
      end else if (wr_stb && addr == CBTF_OFS_MODE) begin
         mode_q <= wdata[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence tw_s;
      wr_stb && addr == CBTF_OFS_TIMING;
   endsequence
   sequence tw_cfg_s;
      tw_s ##0 mode_q == CBTF_MODE_CONFIG;
   endsequence
   rd_idle_a: assert property (
      !$past(rd_stb) |-> rdata == 32'h0000_0000) else $error("rdata not 0");
   // lengths follow a timing write two edges later: register, then decode
   mode_lock_a: assert property (
      tw_s ##0 mode_q != CBTF_MODE_CONFIG |-> ##2 ($stable(phase1_tq)
      && $stable(phase2_tq) && $stable(sjw_tq))) else $error("locked write");
   ph1_load_a: assert property (
      tw_cfg_s |-> ##2 phase1_tq == 4'($past(wdata[13:11], 2)) + 4'h1)
      else $error("phase1 load");
   auto_ph2_a: assert property (
      tw_cfg_s ##0 !wdata[CBTF_FREE_BIT] |-> ##2 phase2_tq == phase1_tq)
      else $error("phase2 auto");
   ph2_order_a: assert property (
      phase2_tq <= phase1_tq && phase2_tq != 4'h0) else $error("phase2 big");
   ph1_range_a: assert property (
      phase1_tq >= 4'h1 && phase1_tq <= 4'h8) else $error("phase1 range");
   sjw_load_a: assert property (
      tw_cfg_s |-> ##2 sjw_tq == 3'($past(wdata[7:6], 2)) + 3'h1)
      else $error("jump width");
   tick_pulse_a: assert property (
      tq_tick |=> !tq_tick) else $error("tick too wide");
   match_cause_a: assert property (
      match_valid |-> $past(msg_valid)) else $error("match no message");
endmodule
bind cbtf_top cbtf_sva sva (
   .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
   .msg_valid(msg_valid), .tq_tick(tq_tick), .phase1_tq(phase1_tq),
   .phase2_tq(phase2_tq), .sjw_tq(sjw_tq), .match_valid(match_valid)
);

// ### tb/cbtf_can_node.sv
// bus node model: drives the receive pin level seen by the block
`timescale 1ns/100ps
module cbtf_can_node (
   input wire logic clk,
   output logic can_rx_pin
);
   // ****************************************
   // line driver
   // ****************************************
   // recessive idle; a level is held until the next call
   initial can_rx_pin = 1'b1;
   task automatic drive(input logic lvl);
      @(posedge clk);
      can_rx_pin <= lvl;
   endtask
endmodule

// ### tb/tb.sv
// testbench: register, timing, filter and line-sampling scenarios
`timescale 1ns/100ps
module tb
   import cbtf_pkg::*;
;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic msg_valid = 1'b0;
   logic [28:0] msg_id = 29'h0000_0000;
   logic [28:0] filt_id0 = 29'h0000_0000;
   logic [28:0] filt_id1 = 29'h0000_0000;
   logic [28:0] mask0 = 29'h0000_0001;
   logic [28:0] mask1 = 29'h0000_0002;
   logic [28:0] mask2 = 29'h0000_0004;
   logic [28:0] mask3 = 29'h0000_0008;
   logic [31:0] rdata;
   logic [3:0] phase1_tq, phase2_tq;
   logic [2:0] sjw_tq;
   logic [4:0] match_fifo;
   logic can_rx_pin, tq_tick, sample_bit, sample_strobe;
   logic wake_detect, match_valid;
   int miscompares = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   cbtf_can_node node (.clk(clk), .can_rx_pin(can_rx_pin));
   cbtf_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .can_rx_pin(can_rx_pin), .msg_id(msg_id), .msg_valid(msg_valid),
      .mask0(mask0), .mask1(mask1), .mask2(mask2), .mask3(mask3),
      .filt_id0(filt_id0), .filt_id1(filt_id1), .tq_tick(tq_tick),
      .sample_bit(sample_bit), .sample_strobe(sample_strobe),
      .wake_detect(wake_detect), .phase1_tq(phase1_tq),
      .phase2_tq(phase2_tq), .sjw_tq(sjw_tq),
      .match_valid(match_valid), .match_fifo(match_fifo));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // prop field fixed at 8 quanta keeps every bit above 7 quanta
   function automatic logic [31:0] tw(input logic [2:0] p1, p2, fl,
      input logic [5:0] quantum_prescaler);
      return {9'h000, fl[2], 3'h0, p2, fl[1], fl[0], p1,
         3'h7, 2'h0, quantum_prescaler};
   endfunction
   task automatic wait_on(input bit s, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((s ? sample_strobe : tq_tick) !== 1'b1 && n < 300);
   endtask
   task automatic send(input logic [28:0] id, input logic hit,
      input logic [4:0] fifo);
      @(posedge clk);
      msg_id <= id;
      msg_valid <= 1'b1;
      @(posedge clk);
      msg_valid <= 1'b0;
      #1 chk(32'(match_valid), 32'(hit));
      if (hit) chk(32'(match_fifo), 32'(fifo));
   endtask
   task automatic t_reset();
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0000_0000);
      rd(CBTF_OFS_TIMING, CBTF_TIMING_RST);
      rd(CBTF_OFS_FILTER, CBTF_FILTER_RST);
      rd(CBTF_OFS_MODE, 32'(CBTF_MODE_RST));
      chk(32'(sjw_tq), 32'h0000_0001);
   endtask
   task automatic t_timing();
      logic [3:0] e1, e2;
      for (int i = 0; i < 8; i++) begin
         e1 = 4'(i) + 4'h1;
         e2 = i[0] ? 4'(8 - i) : (e1 > CBTF_IPT_TQ ? e1 : CBTF_IPT_TQ);
         if (e2 > e1) e2 = e1;
         wr(CBTF_OFS_TIMING, tw(3'(i), 3'(7 - i), {2'b0, i[0]} << 1, 6'h00));
         // effective lengths follow the stored timing one cycle later
         @(posedge clk);
         #1 chk(32'(phase1_tq), 32'(e1));
         chk(32'(phase2_tq), 32'(e2));
         rd(CBTF_OFS_STATUS, {19'h0_0000, 5'(9 + e1 + e2), e2, e1});
      end
      wr(CBTF_OFS_TIMING, 32'hFFFF_FFFF);
      rd(CBTF_OFS_TIMING, CBTF_TIMING_MASK);
   endtask
   task automatic t_mode();
      logic [31:0] old, nw;
      old = CBTF_TIMING_MASK;
      for (int m = 0; m < 8; m++) begin
         nw = tw(3'(m), 3'(m), 3'h2, 6'h02);
         wr(CBTF_OFS_MODE, 32'(m));
         wr(CBTF_OFS_TIMING, nw);
         if (m == 4) old = nw;
         rd(CBTF_OFS_TIMING, old);
      end
      wr(CBTF_OFS_MODE, 32'(CBTF_MODE_CONFIG));
   endtask
   task automatic t_tick();
      int n;
      for (int b = 0; b < 4; b += 3) begin
         wr(CBTF_OFS_TIMING, tw(3'h3, 3'h3, 3'h2, 6'(b)));
         repeat (3) wait_on(1'b0, n);
         chk(32'(n), 32'(2 * b + 2));
      end
   endtask
   task automatic t_line();
      int n;
      for (int w = 0; w < 2; w++) begin
         wr(CBTF_OFS_TIMING, tw(3'h3, 3'h3, {w[0], 1'b1, w[0]}, 6'h02));
         node.drive(1'b0);
         repeat (2) wait_on(1'b1, n);
         chk(32'(sample_bit), 32'h0000_0000);
         chk(32'(wake_detect), 32'h0000_0001);
         node.drive(1'b1);
         repeat (2) wait_on(1'b1, n);
         chk(32'(sample_bit), 32'h0000_0001);
         chk(32'(wake_detect), 32'h0000_0000);
         // one-clock dominant glitch: only the unfiltered line passes it
         node.drive(1'b0);
         node.drive(1'b1);
         n = 0;
         repeat (8) begin
            @(posedge clk);
            #1 if (wake_detect === 1'b1) n++;
         end
         chk(32'(n), w[0] ? 32'h0000_0000 : 32'h0000_0001);
      end
   endtask
   task automatic t_filter();
      logic [7:0] f;
      logic [28:0] t;
      for (int s = 0; s < 4; s++) begin
         f = {1'b1, 2'(s), 5'(28 + s)};
         t = 29'h0AAA_AAAA + 29'(s);
         @(posedge clk);
         filt_id1 <= t;
         filt_id0 <= ~t;
         wr(CBTF_OFS_FILTER, 32'h0000_0000);
         wr(CBTF_OFS_FILTER, {16'h0000, 1'b0, f[6:0], 8'h00});
         send(t ^ ~(29'h1 << s), 1'b0, 5'h00);
         wr(CBTF_OFS_FILTER, {16'h0000, f, 8'h00});
         send(t ^ ~(29'h1 << s), 1'b1, f[4:0]);
         send(t ^ (29'h1 << s), 1'b0, 5'h00);
         wr(CBTF_OFS_FILTER, {16'h0000, f ^ 8'h7F, 8'h00});
         rd(CBTF_OFS_FILTER, {16'h0000, f, 8'h00});
         wr(CBTF_OFS_FILTER, {16'h0000, 8'h00, f});
         send(~t ^ ~(29'h1 << s), 1'b1, f[4:0]);
         rd(CBTF_OFS_FILTER, {16'h0000, 1'b0, f[6:0], f});
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_timing();
      t_mode();
      t_tick();
      t_line();
      t_filter();
      test_done();
   end
   // generous bound: the whole sequence needs about a thousand cycles
   initial begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule
